// [hdl/tag_tx_pkg.sv]
// Constants and types for the tag backscatter transmit path
package tag_tx_pkg;

	typedef enum logic [1:0] {ENC_NRZ, ENC_BIPHASE, ENC_MANCH} enc_type;
	typedef enum logic [1:0] {MOD_DIRECT, MOD_FSK, MOD_PSK} mod_type;

	localparam int CLK_PERIOD_NS = 10;
	localparam int HALF_BIT_CARRIERS = 20;
	localparam int FSK_ZERO_DIV = 8;
	localparam int FSK_ONE_DIV = 10;
	localparam int PSK_DIV = 2;
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_WIDTH = 1;
	localparam logic PSK_ON_ZERO = 1'h0;
	localparam logic PSK_ON_CHANGE = 1'h1;

	// Half period of the FSK subcarrier in carrier cycles
	function automatic logic [3:0] fsk_half(input logic level);
		fsk_half = level ? 4'(FSK_ONE_DIV / 2) : 4'(FSK_ZERO_DIV / 2);
	endfunction

endpackage

// [hdl/bit_fifo.sv]
// Synchronous FIFO holding memory bits ahead of the encoder
`timescale 1ns/10ps
module bit_fifo
	import tag_tx_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready = cnt_q != (AW+1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_b)
		cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// [hdl/backscatter_encoder_modulator.sv]
// Bit encoder and backscatter modulator driving the coil shunt
`timescale 1ns/10ps
module backscatter_encoder_modulator
	import tag_tx_pkg::*;
#(
	parameter int HALF_BIT = HALF_BIT_CARRIERS,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Energy and carrier
	input wire logic power_ok,
	input wire logic carrier_tick,
	// Static configuration
	input wire enc_type enc_sel,
	input wire mod_type mod_sel,
	input wire logic psk_sel,
	// Memory bit stream
	input wire logic mem_bit,
	input wire logic mem_valid,
	output logic mem_ready,
	// Coil shunt
	output logic shunt_on,
	output logic sending
);
	localparam int CW = $clog2(HALF_BIT);

	// ==========================================
	// Buffer between memory array and encoder
	logic fifo_bit;
	logic fifo_valid;
	logic pop;

	bit_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_data(mem_bit),
		.in_valid(mem_valid),
		.in_ready(mem_ready),
		.out_data(fifo_bit),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	// ==========================================
	// Power-up and configuration capture
	logic run_q;
	enc_type enc_q;
	mod_type mod_q;
	logic psk_var_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			run_q <= 1'h0;
		end else begin
			run_q <= power_ok;
		end
	end

	// Sampled only while idle, so a change mid-field cannot corrupt a frame
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			enc_q <= ENC_NRZ;
			mod_q <= MOD_DIRECT;
			psk_var_q <= PSK_ON_ZERO;
		end else if (!run_q) begin
			enc_q <= enc_sel;
			mod_q <= mod_sel;
			psk_var_q <= psk_sel;
		end
	end

	// ==========================================
	// Carrier divider: half-bit enable
	logic [CW-1:0] car_q;
	logic half_en;

	assign half_en = run_q && carrier_tick && (car_q == CW'(HALF_BIT-1));

	always_ff @(posedge clk) begin
		if (!rst_b || !run_q) begin
			car_q <= '0;
		end else if (carrier_tick) begin
			car_q <= half_en ? '0 : car_q + 1'b1;
		end
	end

	// ==========================================
	// Encoder
	logic mid_q;
	logic act_q;
	logic bit_q;
	logic level_q;
	logic level_d;
	logic start_step;
	logic mid_step;

	assign start_step = half_en && !mid_q;
	assign mid_step = half_en && mid_q;
	assign pop = start_step && fifo_valid;

	always_comb begin
		level_d = level_q;
		if (start_step) begin
			if (!fifo_valid) begin
				level_d = 1'h0;
			end else begin
				unique case (enc_q)
					ENC_NRZ: level_d = fifo_bit;
					ENC_BIPHASE: level_d = !level_q;
					ENC_MANCH: level_d = fifo_bit;
					default: level_d = 1'h0;
				endcase
			end
		end else if (mid_step) begin
			unique case (enc_q)
				ENC_NRZ: level_d = bit_q;
				ENC_BIPHASE: level_d = level_q ^ bit_q;
				ENC_MANCH: level_d = !bit_q;
				default: level_d = 1'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !run_q) begin
			mid_q <= 1'h0;
			act_q <= 1'h0;
			bit_q <= 1'h0;
			level_q <= 1'h0;
		end else begin
			level_q <= level_d;
			if (start_step) begin
				act_q <= fifo_valid;
				mid_q <= fifo_valid;
				if (fifo_valid) begin
					bit_q <= fifo_bit;
				end
			end else if (mid_step) begin
				mid_q <= 1'h0;
			end
		end
	end

	// ==========================================
	// Subcarriers
	logic [3:0] fsk_cnt_q;
	logic fsk_q;
	logic psk_clk_q;
	logic phase_q;
	logic phase_flip;

	always_ff @(posedge clk) begin
		if (!rst_b || !run_q) begin
			fsk_cnt_q <= '0;
			fsk_q <= 1'h0;
		end else if (carrier_tick) begin
			if (fsk_cnt_q >= fsk_half(level_q) - 4'h1) begin
				fsk_cnt_q <= '0;
				fsk_q <= !fsk_q;
			end else begin
				fsk_cnt_q <= fsk_cnt_q + 4'h1;
			end
		end
	end

	// Carrier/2 toggles every carrier cycle; other ratios are not offered
	always_ff @(posedge clk) begin
		if (!rst_b || !run_q) begin
			psk_clk_q <= 1'h0;
		end else if (carrier_tick) begin
			psk_clk_q <= !psk_clk_q;
		end
	end

	// One inversion per zero: a mid step that stays low must not flip back
	assign phase_flip = half_en && act_q && (psk_var_q == PSK_ON_ZERO
		? !level_d && (start_step || level_q) : level_d != level_q);

	always_ff @(posedge clk) begin
		if (!rst_b || !run_q) begin
			phase_q <= 1'h0;
		end else if (phase_flip) begin
			phase_q <= !phase_q;
		end
	end

	// ==========================================
	// Modulator and shunt
	logic shunt_q;

	always_ff @(posedge clk) begin
		if (!rst_b || !run_q) begin
			shunt_q <= 1'h0;
		end else begin
			unique case (mod_q)
				MOD_DIRECT: shunt_q <= level_q;
				MOD_FSK: shunt_q <= act_q && fsk_q;
				MOD_PSK: shunt_q <= act_q && (psk_clk_q ^ phase_q);
				default: shunt_q <= 1'h0;
			endcase
		end
	end

	assign shunt_on = shunt_q;
	assign sending = act_q;

	// ==========================================
	// Checks
	a_idle_shunt_off: assert property (@(posedge clk) disable iff (!rst_b)
		!run_q |=> !shunt_on) else $error("shunt active while unpowered");

	a_bit_from_fifo: assert property (@(posedge clk) disable iff (!rst_b)
		pop |=> bit_q == $past(fifo_bit) && act_q) else $error("bit not loaded");

	a_nrz_direct: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && enc_q == ENC_NRZ && act_q && mid_step |=> level_q == bit_q)
		else $error("nrz level differs from bit");

	a_biphase_edge: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && enc_q == ENC_BIPHASE && pop |=> level_q != $past(level_q))
		else $error("biphase boundary lacks edge");

	a_biphase_mid: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && enc_q == ENC_BIPHASE && mid_step
		|=> level_q == ($past(level_q) ^ $past(bit_q)))
		else $error("biphase mid edge wrong");

	a_manch_mid: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && enc_q == ENC_MANCH && mid_step |=> level_q != $past(level_q))
		else $error("manchester mid edge missing");

	a_direct_follow: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && power_ok && mod_q == MOD_DIRECT && $changed(level_q)
		|=> shunt_on == $past(level_q)) else $error("direct shunt lags level");

	a_fsk_period: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && mod_q == MOD_FSK && carrier_tick && fsk_cnt_q == 4'h0
		|=> fsk_cnt_q == 4'h1 && fsk_q == $past(fsk_q))
		else $error("fsk subcarrier toggled early");

	a_fsk_bound: assert property (@(posedge clk) disable iff (!rst_b)
		fsk_cnt_q < 4'(FSK_ONE_DIV / 2)) else $error("fsk counter overrun");

	a_psk_phase: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && mod_q == MOD_PSK && phase_flip |=> phase_q != $past(phase_q))
		else $error("psk phase not inverted");

	a_psk_zero_once: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && psk_var_q == PSK_ON_ZERO && mid_step && !level_q && !level_d
		|=> phase_q == $past(phase_q)) else $error("psk phase flipped twice in a zero");

	a_psk_rate: assert property (@(posedge clk) disable iff (!rst_b)
		run_q && power_ok && carrier_tick |=> psk_clk_q != $past(psk_clk_q))
		else $error("psk clock not at carrier/2");

	a_cfg_static: assert property (@(posedge clk) disable iff (!rst_b)
		run_q |=> enc_q == $past(enc_q) && mod_q == $past(mod_q))
		else $error("configuration changed while running");

	c_nrz_send: cover property (@(posedge clk) disable iff (!rst_b)
		enc_q == ENC_NRZ && pop);
	c_biphase_send: cover property (@(posedge clk) disable iff (!rst_b)
		enc_q == ENC_BIPHASE && mid_step && bit_q);
	c_fsk_send: cover property (@(posedge clk) disable iff (!rst_b)
		mod_q == MOD_FSK && act_q && $rose(shunt_on));
	c_psk_flip: cover property (@(posedge clk) disable iff (!rst_b)
		mod_q == MOD_PSK && phase_flip);

endmodule

// [verif/reader_model.sv]
// Reader model: steady carrier and peak detection of the coil shunt
`timescale 1ns/10ps
module reader_model #(
	parameter int HB = 10
) (
	// Carrier
	input wire logic clk,
	output logic carrier_tick,
	// Detected envelope
	input wire logic shunt_on,
	input wire logic sending,
	// Measurements
	output logic pair_v,
	output logic [1:0] pair,
	output logic [7:0] period,
	output logic [7:0] slips
);
	logic [7:0] pos = 8'h00;
	logic [7:0] since = 8'h00;
	logic last = 1'b0;
	logic was = 1'b0;
	initial begin
		carrier_tick = 1'b0;
		pair_v = 1'b0;
		pair = 2'h0;
		period = 8'h00;
		slips = 8'h00;
	end
	// ==========================================
	// Carrier never pauses, one cycle per two clocks
	always @(negedge clk) carrier_tick <= ~carrier_tick;
	// ==========================================
	// Envelope sampled once per carrier cycle
	always @(posedge clk) begin
		pair_v <= 1'b0;
		if (carrier_tick) begin
			last <= shunt_on;
			was <= sending;
			since <= since + 8'h01;
			if (shunt_on && !last) begin
				period <= since + 8'h01;
				since <= 8'h00;
			end
			// First cycle of a burst has no valid predecessor
			if (sending && was && shunt_on == last) slips <= slips + 8'h01;
			pos <= (!sending || pos == 8'(2 * HB - 1)) ? 8'h00 : pos + 8'h01;
			if (sending && pos == 8'(HB / 2)) pair[1] <= shunt_on;
			if (sending && pos == 8'(HB + HB / 2)) begin
				pair[0] <= shunt_on;
				pair_v <= 1'b1;
			end
		end
	end
endmodule

// [verif/backscatter_encoder_modulator_bench.sv]
// Self-checking bench for the backscatter encoder and modulator
`timescale 1ns/10ps
module backscatter_encoder_modulator_bench;
	import tag_tx_pkg::*;
	localparam int HB = 10;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic power_ok = 1'b0;
	logic psk_sel = 1'b0;
	logic mem_bit = 1'b0;
	logic mem_valid = 1'b0;
	logic carrier_tick, mem_ready, shunt_on, sending, pair_v;
	logic [1:0] pair;
	logic [7:0] period, slips, s0;
	logic [31:0] bits;
	enc_type enc_sel = ENC_NRZ;
	enc_type cur_enc = ENC_NRZ;
	logic prev_half = 1'b0;
	mod_type mod_sel = MOD_DIRECT;
	int num_errors = 0;
	int n_checks = 0;
	int e;
	logic [1:0] expq[$];
	always #5 clk = ~clk;
	backscatter_encoder_modulator #(.HALF_BIT(HB)) i_dut (.clk(clk), .rst_b(rst_b),
		.power_ok(power_ok), .carrier_tick(carrier_tick), .enc_sel(enc_sel),
		.mod_sel(mod_sel), .psk_sel(psk_sel), .mem_bit(mem_bit), .mem_valid(mem_valid),
		.mem_ready(mem_ready), .shunt_on(shunt_on), .sending(sending));
	reader_model #(.HB(HB)) i_reader (.clk(clk), .carrier_tick(carrier_tick),
		.shunt_on(shunt_on), .sending(sending), .pair_v(pair_v), .pair(pair),
		.period(period), .slips(slips));
	// ==========================================
	// Helpers
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask
	// Loads n bits while unpowered, so the burst runs without gaps
	task automatic start(input enc_type en, input mod_type md, input int n);
		logic lv;
		logic h;
		lv = 1'b0;
		cur_enc = en;
		prev_half = 1'b0;
		enc_sel = en;
		mod_sel = md;
		mem_valid = 1'b1;
		for (int i = 0; i < n; i++) begin
			mem_bit = bits[i];
			h = en == ENC_MANCH ? ~bits[i] : bits[i];
			if (en == ENC_BIPHASE) begin
				lv = ~lv;
				h = bits[i] ? ~lv : lv;
			end
			if (md == MOD_DIRECT) expq.push_back({en == ENC_BIPHASE ? lv : bits[i], h});
			lv = h;
			@(negedge clk);
		end
		mem_valid = 1'b0;
		check(8'(mem_ready), 8'(n < FIFO_DEPTH), "fifo ready");
		power_ok = 1'b1;
		@(negedge clk);
		enc_sel = en == ENC_MANCH ? ENC_NRZ : ENC_MANCH;
		for (int k = 0; k < 200 && sending !== 1'b1; k++) @(negedge clk);
		check(8'(sending), 8'h01, "burst start");
	endtask
	task automatic stop();
		for (int k = 0; k < 3000 && sending === 1'b1; k++) @(negedge clk);
		check(8'(sending), 8'h00, "burst end");
		power_ok = 1'b0;
		repeat (4) @(negedge clk);
		check(8'(expq.size()), 8'h00, "symbols missing");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================
	// Result watcher for direct modulation
	always @(posedge clk) begin
		if (pair_v && mod_sel == MOD_DIRECT) begin
			if (cur_enc == ENC_BIPHASE) check(8'(pair[1] ^ prev_half), 8'h01, "boundary edge");
			prev_half = pair[0];
			if (expq.size() == 0) check(8'(pair), 8'hFF, "unexpected symbol");
			else check(8'(pair), 8'(expq.pop_front()), "symbol halves");
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
	// ==========================================
	// Tests
	initial begin
		void'($urandom(32'h541A6A60));
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		check({6'h00, shunt_on, sending}, 8'h00, "idle after reset");
		check(8'(mem_ready), 8'h01, "ready after reset");
		for (int i = 0; i < 3; i++) begin
			bits = $urandom();
			start(enc_type'(2'(i)), MOD_DIRECT, FIFO_DEPTH);
			stop();
			$display("test direct encoding %0d done", i);
		end
		bits = 32'h000000F0;
		start(ENC_NRZ, MOD_FSK, 8);
		repeat (100) @(negedge clk);
		check(period, 8'(FSK_ZERO_DIV), "fsk zero period");
		// Deep enough into the ones that a whole slow period has been seen
		repeat (120) @(negedge clk);
		check(period, 8'(FSK_ONE_DIV), "fsk one period");
		stop();
		$display("test fsk done");
		for (int p = 0; p < 2; p++) begin
			bits = {24'h000000, 8'($urandom())};
			bits[0] = p == 0;
			psk_sel = p[0];
			e = 0;
			for (int i = 0; i < 8; i++) begin
				e += p == 0 ? !bits[i] : (i > 0 && bits[i] != bits[i-1]);
			end
			start(ENC_NRZ, MOD_PSK, 8);
			s0 = slips;
			stop();
			check(slips - s0, 8'(e), "psk phase flips");
			$display("test psk variant %0d done", p);
		end
		tally_and_finish();
	end
endmodule
